//--- bench/pfs_adc_model.sv
// behavioural adc that samples the held integrator output and answers after a set delay
`timescale 1ns/100ps

module pfs_adc_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // conversion control
    input  wire logic        sample,
    input  wire logic [7:0]  dly,
    input  wire logic [15:0] val,
    // result
    output logic             done,
    output logic [15:0]      data
);
    logic [7:0] cnt_ff;
    logic       busy_ff;
    logic       prev_ff;

    // data toggles outside the done cycle so a stale value is never mistaken for a result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 8'h00;
            busy_ff <= 1'b0;
            prev_ff <= 1'b0;
            done    <= 1'b0;
            data    <= 16'h0000;
        end else begin
            prev_ff <= sample;
            done    <= 1'b0;
            data    <= ~data;
            if (sample && !prev_ff) begin
                busy_ff <= 1'b1;
                cnt_ff  <= dly;
            end else if (busy_ff) begin
                if (cnt_ff == 8'h00) begin
                    busy_ff <= 1'b0;
                    done    <= 1'b1;
                    data    <= val;
                end else begin
                    cnt_ff <= cnt_ff - 8'h01;
                end
            end
        end
    end
endmodule // pfs_adc_model

//--- bench/pfs_sequencer_tb.sv
// self-checking bench for the float pulse sequencer
`timescale 1ns/100ps
`include "pfs_defines.svh"

module pfs_sequencer_tb;
    logic             CLK = 1'b0;
    logic             RST_N = 1'b0;
    logic [5:0]       AVS_ADDRESS = 6'h00;
    logic             AVS_READ = 1'b0;
    logic             AVS_WRITE = 1'b0;
    logic [31:0]      AVS_WRITEDATA = 32'h0;
    logic [3:0]       AVS_BYTEENABLE = 4'hf;
    logic [31:0]      AVS_READDATA;
    logic             AVS_WAITREQUEST;
    logic             ADC_DONE;
    logic [15:0]      ADC_DATA;
    pfs_pkg::pfs_sw_t SW_CTRL;
    logic             ADC_SAMPLE;
    logic [7:0]       dly = 8'h03;
    logic [15:0]      val = 16'h1234;
    logic [3:0]       be = 4'hf;
    logic [31:0]      q;
    logic             prev_rst = 1'b0;
    logic             prev_pos = 1'b0;
    int               cnt[7];
    int               errors = 0;
    int               n_compared = 0;

    always #50 CLK = ~CLK;

    pfs_sequencer uut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .ADC_DONE(ADC_DONE),
        .ADC_DATA(ADC_DATA), .SW_CTRL(SW_CTRL), .ADC_SAMPLE(ADC_SAMPLE));

    pfs_adc_model adc (.clk(CLK), .rst_n(RST_N), .sample(ADC_SAMPLE), .dly(dly), .val(val),
        .done(ADC_DONE), .data(ADC_DATA));

    // ------------------------------------------------------------
    // phase monitor: 0 pos, 1 dump, 2 neg tail, 3 pd on, 4 led, 5 hold, 6 illegal combos
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        cnt[0] += SW_CTRL.int_pos;
        cnt[1] += SW_CTRL.int_neg & SW_CTRL.pd_connect;
        cnt[2] += SW_CTRL.int_neg & !SW_CTRL.pd_connect;
        cnt[3] += SW_CTRL.pd_connect;
        cnt[4] += SW_CTRL.led_fire;
        cnt[5] += SW_CTRL.int_hold;
        cnt[6] += (SW_CTRL.led_fire & SW_CTRL.pd_connect) | (SW_CTRL.int_pos & SW_CTRL.pd_connect)
            | (SW_CTRL.int_pos & !prev_pos & !prev_rst)
            | ((SW_CTRL.int_pos | SW_CTRL.int_neg) & !SW_CTRL.bpf_bypass);
        prev_pos = SW_CTRL.int_pos;
        prev_rst = SW_CTRL.int_reset;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask

    // holds the request until the edge where waitrequest is seen low, then releases it
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        @(posedge CLK);
        AVS_ADDRESS    <= a;
        AVS_WRITEDATA  <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE      <= w;
        AVS_READ       <= !w;
        for (i = 0; i < 50; i++) begin
            @(posedge CLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        if (i == 50) begin
            errors++;
            final_report();
        end
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // clears the monitor, starts a run and polls status until the sequencer is idle again
    task automatic run(input logic [31:0] ctrl);
        int i;
        @(negedge CLK);
        foreach (cnt[k]) cnt[k] = 0;
        bus(1'b1, `PFS_ADDR_CTRL, ctrl);
        for (i = 0; i < 200; i++) begin
            bus(1'b0, `PFS_ADDR_STATUS, 32'h0);
            if (q[3:0] === 4'h0) break;
        end
        if (i == 200) begin
            errors++;
            final_report();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        rdc(`PFS_ADDR_LED_SEL, 32'h5);
        rdc(`PFS_ADDR_TIMING0, `PFS_RST_TIMING0);
        rdc(`PFS_ADDR_TIMING1, `PFS_RST_TIMING1);
        rdc(6'h3c, 32'h0);
        be = 4'h0;
        bus(1'b1, `PFS_ADDR_LED_SEL, 32'h0);
        be = 4'hf;
        rdc(`PFS_ADDR_LED_SEL, 32'h5);
        // precon 2, float 4, pos 1, dump 2, neg tail 1, led at 2 for 3 us
        bus(1'b1, `PFS_ADDR_TIMING0, 32'h0204_0102);
        bus(1'b1, `PFS_ADDR_TIMING1, 32'h0100_0203);
        rdc(`PFS_ADDR_TIMING0, 32'h0204_0102);
        // input bias, cathode override and analog path word live outside this block
        bus(1'b1, `PFS_ADDR_LED_SEL, 32'h0);
        bus(1'b1, `PFS_ADDR_FLT_EN, 32'h0);
        run(32'h1);
        chk(cnt[3], 3 * `PFS_US_CYC);
        chk(cnt[4] + cnt[0], 0);
        bus(1'b1, `PFS_ADDR_FLT_EN, 32'h3);
        run(32'h1);
        chk(cnt[0], 1 * `PFS_US_CYC);
        chk(cnt[1], 2 * `PFS_US_CYC);
        chk(cnt[2], 1 * `PFS_US_CYC);
        chk(cnt[3], 4 * `PFS_US_CYC);
        chk(cnt[6], 0);
        chk(cnt[5] >= 3, 1);
        rdc(`PFS_ADDR_DATA_A, 32'h1234);
        rdc(`PFS_ADDR_FIFO, 32'h1234);
        dly = 8'h28;
        val = 16'hbeef;
        bus(1'b1, `PFS_ADDR_FLT_EN, 32'hc);
        run(32'h7);
        chk(cnt[4] > 0, 1);
        chk(cnt[6], 0);
        chk(cnt[5] >= 40, 1);
        rdc(`PFS_ADDR_DATA_B, 32'hbeef);
        final_report();
    end
endmodule // pfs_sequencer_tb

//--- design/pfs_defines.svh
// register offsets, field positions, reset values and timing counts for the float sequencer
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// ------------------------------------------------------------
// register byte addresses (word aligned)
// ------------------------------------------------------------
`define PFS_ADDR_CTRL      6'h00
`define PFS_ADDR_LED_SEL   6'h04
`define PFS_ADDR_FLT_EN    6'h08
`define PFS_ADDR_TIMING0   6'h0c
`define PFS_ADDR_TIMING1   6'h10
`define PFS_ADDR_STATUS    6'h14
`define PFS_ADDR_DATA_A    6'h18
`define PFS_ADDR_DATA_B    6'h1c
`define PFS_ADDR_FIFO      6'h20

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PFS_CTRL_START     0
`define PFS_CTRL_SLOT      1
`define PFS_LED_SEL_A_LO   0
`define PFS_LED_SEL_B_LO   2
`define PFS_FLT_EN_A_LO    0
`define PFS_FLT_EN_B_LO    2
`define PFS_FLT_ON         2'h3
`define PFS_LED_NONE       2'h0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PFS_RST_TIMING0    32'h0010_0004
`define PFS_RST_TIMING1    32'h0002_0008

// ------------------------------------------------------------
// timing: one microsecond tick from a 10 MHz clock
// ------------------------------------------------------------
`define PFS_CLK_HZ         10000000
`define PFS_US_NS          1000
`define PFS_CLK_NS         100
`define PFS_US_CYC         (`PFS_US_NS / `PFS_CLK_NS)
`define PFS_FLOAT_MIN_US   4
`define PFS_DUMP_MAX_US    2
`define PFS_RSTINT_CYC     1

`endif

//--- design/pfs_pkg.sv
// types shared by the float pulse sequencer
package pfs_pkg;

    // ------------------------------------------------------------
    // sequencer states, gray coded along the float path
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PFS_IDLE  = 4'h0,
        PFS_PRECN = 4'h1,
        PFS_FLOAT = 4'h3,
        PFS_IRST  = 4'h2,
        PFS_POS   = 4'h6,
        PFS_NEGD  = 4'h7,
        PFS_NEGT  = 4'h5,
        PFS_HOLD  = 4'h4,
        PFS_PCON  = 4'hc
    } pfs_state_t;

    // ------------------------------------------------------------
    // analog switch controls
    // ------------------------------------------------------------
    typedef struct packed {
        logic pd_connect;
        logic tia_connect;
        logic bpf_bypass;
        logic int_reset;
        logic int_pos;
        logic int_neg;
        logic int_hold;
        logic led_fire;
    } pfs_sw_t;

    // ------------------------------------------------------------
    // phase lengths in microseconds
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] precon_us;
        logic [7:0] float_us;
        logic [7:0] pos_us;
        logic [7:0] dump_us;
        logic [7:0] negt_us;
        logic [7:0] pulse_us;
        logic [7:0] led_off_us;
        logic [7:0] led_w_us;
    } pfs_timing_t;

endpackage

//--- design/pfs_sequencer.sv
// photodiode pulse-connect and float-mode sequencer with avalon-mm registers
//
// Function
// - pulse connect drives input switch with LED timing
// - results via FIFO and per-slot data registers
// - float: precondition, then disconnect for float time
// - float path uses TIA and integrator, BPF bypassed
// - whole dump integrated in negative phase
// - precondition: PD on TIA, integrator off
// - float start isolates PD and TIA input
// - integrator reset right before positive phase
// - synchronous LED fires between disconnect and reconnect
// - positive phase runs while PD floats
// - negative phase continues until hold point
// - reconnect PD during negative phase for dump
// - disconnect TIA after dump, negative phase continues
// - hold integrator output until ADC samples
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`include "pfs_defines.svh"

module pfs_sequencer (
    // clock and reset
    input  wire logic           CLK,
    input  wire logic           RST_N,
    // avalon-mm slave
    input  wire logic [5:0]     AVS_ADDRESS,
    input  wire logic           AVS_READ,
    input  wire logic           AVS_WRITE,
    input  wire logic [31:0]    AVS_WRITEDATA,
    input  wire logic [3:0]     AVS_BYTEENABLE,
    output logic [31:0]         AVS_READDATA,
    output logic                AVS_WAITREQUEST,
    // adc result
    input  wire logic           ADC_DONE,
    input  wire logic [15:0]    ADC_DATA,
    // analog switch controls
    output pfs_pkg::pfs_sw_t    SW_CTRL,
    output logic                ADC_SAMPLE
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]           led_sel_a_ff;
    logic [1:0]           led_sel_b_ff;
    logic [1:0]           flt_en_a_ff;
    logic [1:0]           flt_en_b_ff;
    logic                 sync_led_ff;
    logic                 slot_ff;
    logic                 start_ff;
    pfs_pkg::pfs_timing_t tim_ff;
    logic [15:0]          data_a_ff;
    logic [15:0]          data_b_ff;
    logic [15:0]          fifo_mem [0:7];
    logic [2:0]           fifo_wp_ff;
    logic [2:0]           fifo_rp_ff;
    logic [3:0]           fifo_cnt_ff;
    logic                 ack_ff;
    logic [31:0]          rdata_ff;

    pfs_pkg::pfs_state_t  state_ff;
    pfs_pkg::pfs_state_t  nxt_state;
    logic [9:0]           us_now;
    logic                 restart;
    logic                 cur_slot_ff;

    wire logic req     = (AVS_READ | AVS_WRITE) & ~ack_ff;
    wire logic wr_go   = AVS_WRITE & ack_ff;
    wire logic rd_go   = AVS_READ & ~ack_ff;
    wire logic fifo_rd = rd_go & (AVS_ADDRESS == `PFS_ADDR_FIFO) & (fifo_cnt_ff != 4'h0);
    wire logic fifo_wr = ADC_DONE & (fifo_cnt_ff != 4'h8);

    // one wait cycle: read data loaded at the first edge, writes land with waitrequest low
    assign AVS_WAITREQUEST = ~ack_ff;
    assign AVS_READDATA    = rdata_ff;

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            led_sel_a_ff <= 2'h1;
            led_sel_b_ff <= 2'h1;
            flt_en_a_ff  <= 2'h0;
            flt_en_b_ff  <= 2'h0;
            sync_led_ff  <= 1'b0;
            slot_ff      <= 1'b0;
            tim_ff       <= {`PFS_RST_TIMING0, `PFS_RST_TIMING1};
        end else if (wr_go && AVS_BYTEENABLE[0]) begin
            unique case (AVS_ADDRESS)
                `PFS_ADDR_CTRL: begin
                    slot_ff     <= AVS_WRITEDATA[`PFS_CTRL_SLOT];
                    sync_led_ff <= AVS_WRITEDATA[2];
                end
                `PFS_ADDR_LED_SEL: begin
                    led_sel_a_ff <= AVS_WRITEDATA[`PFS_LED_SEL_A_LO +: 2];
                    led_sel_b_ff <= AVS_WRITEDATA[`PFS_LED_SEL_B_LO +: 2];
                end
                `PFS_ADDR_FLT_EN: begin
                    flt_en_a_ff <= AVS_WRITEDATA[`PFS_FLT_EN_A_LO +: 2];
                    flt_en_b_ff <= AVS_WRITEDATA[`PFS_FLT_EN_B_LO +: 2];
                end
                `PFS_ADDR_TIMING0: tim_ff[63:32] <= AVS_WRITEDATA;
                `PFS_ADDR_TIMING1: tim_ff[31:0]  <= AVS_WRITEDATA;
                default: ;
            endcase
        end
    end

    // start is a self-clearing strobe
    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= wr_go & AVS_BYTEENABLE[0] & (AVS_ADDRESS == `PFS_ADDR_CTRL)
                        & AVS_WRITEDATA[`PFS_CTRL_START];
        end
    end

    // ------------------------------------------------------------
    // results: per-slot data registers and a small fifo
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            data_a_ff <= 16'h0000;
            data_b_ff <= 16'h0000;
        end else if (ADC_DONE) begin
            if (cur_slot_ff) data_b_ff <= ADC_DATA;
            else             data_a_ff <= ADC_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (fifo_wr) fifo_mem[fifo_wp_ff] <= ADC_DATA;
    end

    // a full fifo drops new samples; the data registers still update
    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fifo_wp_ff  <= 3'h0;
            fifo_rp_ff  <= 3'h0;
            fifo_cnt_ff <= 4'h0;
        end else begin
            if (fifo_wr) fifo_wp_ff <= fifo_wp_ff + 3'h1;
            if (fifo_rd) fifo_rp_ff <= fifo_rp_ff + 3'h1;
            fifo_cnt_ff <= fifo_cnt_ff + {3'h0, fifo_wr} - {3'h0, fifo_rd};
        end
    end

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_go) begin
            unique case (AVS_ADDRESS)
                `PFS_ADDR_CTRL:    rdata_ff <= {29'h0, sync_led_ff, slot_ff, 1'b0};
                `PFS_ADDR_LED_SEL: rdata_ff <= {28'h0, led_sel_b_ff, led_sel_a_ff};
                `PFS_ADDR_FLT_EN:  rdata_ff <= {28'h0, flt_en_b_ff, flt_en_a_ff};
                `PFS_ADDR_TIMING0: rdata_ff <= tim_ff[63:32];
                `PFS_ADDR_TIMING1: rdata_ff <= tim_ff[31:0];
                `PFS_ADDR_STATUS:  rdata_ff <= {24'h0, fifo_cnt_ff, state_ff};
                `PFS_ADDR_DATA_A:  rdata_ff <= {16'h0, data_a_ff};
                `PFS_ADDR_DATA_B:  rdata_ff <= {16'h0, data_b_ff};
                `PFS_ADDR_FIFO:    rdata_ff <= (fifo_cnt_ff != 4'h0) ?
                                               {16'h0, fifo_mem[fifo_rp_ff]} : 32'h0;
                default:           rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode selection for the slot being run
    // ------------------------------------------------------------
    // while idle the slot about to be started decides the mode
    wire logic       run_slot = (state_ff == pfs_pkg::PFS_IDLE) ? slot_ff : cur_slot_ff;
    wire logic [1:0] led_sel  = run_slot ? led_sel_b_ff : led_sel_a_ff;
    wire logic [1:0] flt_en   = run_slot ? flt_en_b_ff  : flt_en_a_ff;
    wire logic       no_led   = (led_sel == `PFS_LED_NONE);
    wire logic       flt_mode = no_led & (flt_en == `PFS_FLT_ON);

    // ------------------------------------------------------------
    // phase boundaries from one microsecond counter
    // ------------------------------------------------------------
    pfs_us_timer u_timer (
        .clk     (CLK),
        .rst_n   (rst_n_ff),
        .restart (restart),
        .us_ff   (us_now)
    );

    // boundaries are cumulative sums of phase lengths
    wire logic [9:0] t_a = {2'h0, tim_ff.precon_us};
    wire logic [9:0] t_b = t_a + {2'h0, tim_ff.float_us};
    wire logic [9:0] t_c = t_b + {2'h0, tim_ff.pos_us};
    wire logic [9:0] t_e = t_c + {2'h0, tim_ff.dump_us};
    wire logic [9:0] t_f = t_e + {2'h0, tim_ff.negt_us};
    wire logic [9:0] led_on  = {2'h0, tim_ff.led_off_us};
    wire logic [9:0] led_end = led_on + {2'h0, tim_ff.led_w_us};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        restart   = 1'b0;
        unique case (state_ff)
            pfs_pkg::PFS_IDLE: begin
                if (start_ff) begin
                    restart = 1'b1;
                    if (flt_mode)    nxt_state = pfs_pkg::PFS_PRECN;
                    else if (no_led) nxt_state = pfs_pkg::PFS_PCON;
                end
            end
            pfs_pkg::PFS_PRECN: if (us_now >= t_a) nxt_state = pfs_pkg::PFS_FLOAT;
            // the integrator reset takes the last microsecond of the float time
            pfs_pkg::PFS_FLOAT: if (us_now >= t_b - 10'h001) nxt_state = pfs_pkg::PFS_IRST;
            pfs_pkg::PFS_IRST:  if (us_now >= t_b) nxt_state = pfs_pkg::PFS_POS;
            pfs_pkg::PFS_POS:   if (us_now >= t_c) nxt_state = pfs_pkg::PFS_NEGD;
            pfs_pkg::PFS_NEGD:  if (us_now >= t_e) nxt_state = pfs_pkg::PFS_NEGT;
            pfs_pkg::PFS_NEGT:  if (us_now >= t_f) nxt_state = pfs_pkg::PFS_HOLD;
            pfs_pkg::PFS_HOLD:  if (ADC_DONE) nxt_state = pfs_pkg::PFS_IDLE;
            pfs_pkg::PFS_PCON:  if (us_now >= led_end) nxt_state = pfs_pkg::PFS_HOLD;
            default:            nxt_state = pfs_pkg::PFS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= pfs_pkg::PFS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cur_slot_ff <= 1'b0;
        end else if (state_ff == pfs_pkg::PFS_IDLE && start_ff) begin
            cur_slot_ff <= slot_ff;
        end
    end

    // ------------------------------------------------------------
    // switch outputs, registered from the next state
    // ------------------------------------------------------------
    pfs_pkg::pfs_sw_t nxt_sw;
    pfs_pkg::pfs_sw_t sw_ff;
    logic             sample_ff;

    wire logic in_float = (nxt_state == pfs_pkg::PFS_FLOAT) | (nxt_state == pfs_pkg::PFS_IRST)
                        | (nxt_state == pfs_pkg::PFS_POS);
    // the counter is stale in the restart cycle, so no window opens there
    wire logic led_win  = ~restart & (us_now >= led_on) & (us_now < led_end);

    always_comb begin
        nxt_sw = '0;
        unique case (nxt_state)
            pfs_pkg::PFS_PRECN: nxt_sw.pd_connect = 1'b1;
            pfs_pkg::PFS_PCON:  nxt_sw.pd_connect = led_win;
            pfs_pkg::PFS_IRST:  nxt_sw.int_reset  = 1'b1;
            pfs_pkg::PFS_POS:   nxt_sw.int_pos    = 1'b1;
            pfs_pkg::PFS_NEGD: begin
                nxt_sw.pd_connect  = 1'b1;
                nxt_sw.int_neg     = 1'b1;
            end
            pfs_pkg::PFS_NEGT:  nxt_sw.int_neg    = 1'b1;
            pfs_pkg::PFS_HOLD:  nxt_sw.int_hold   = 1'b1;
            default: ;
        endcase
        // tia follows the photodiode switch; isolated while floating
        nxt_sw.tia_connect = nxt_sw.pd_connect;
        nxt_sw.bpf_bypass  = flt_mode & (nxt_state != pfs_pkg::PFS_IDLE);
        nxt_sw.led_fire    = sync_led_ff & in_float & led_win;
    end

    always_ff @(posedge CLK or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sw_ff     <= '0;
            sample_ff <= 1'b0;
        end else begin
            sw_ff     <= nxt_sw;
            sample_ff <= (nxt_state == pfs_pkg::PFS_HOLD);
        end
    end

    assign SW_CTRL    = sw_ff;
    assign ADC_SAMPLE = sample_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_float_isolated: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (state_ff == pfs_pkg::PFS_POS) |-> (!SW_CTRL.pd_connect && !SW_CTRL.tia_connect))
        else $error("photodiode connected while floating");
    a_reset_before_pos: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        $rose(SW_CTRL.int_pos) |-> $past(SW_CTRL.int_reset))
        else $error("positive phase without prior integrator reset");
    a_precon_int_off: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (state_ff == pfs_pkg::PFS_PRECN) |-> (SW_CTRL.pd_connect && !SW_CTRL.int_pos
        && !SW_CTRL.int_neg))
        else $error("precondition switches wrong");
    a_dump_in_neg: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (SW_CTRL.pd_connect && flt_mode && state_ff != pfs_pkg::PFS_PRECN
        && state_ff != pfs_pkg::PFS_FLOAT) |-> SW_CTRL.int_neg)
        else $error("charge dump outside negative phase");
    a_neg_to_hold: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        $fell(SW_CTRL.int_neg) |-> SW_CTRL.int_hold)
        else $error("negative phase ended without hold");
    a_hold_sample: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (SW_CTRL.int_hold && !ADC_DONE) |=> SW_CTRL.int_hold)
        else $error("hold released before adc sample");
    a_bpf_bypass: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (SW_CTRL.int_pos && flt_mode) |-> SW_CTRL.bpf_bypass)
        else $error("filter not bypassed in float mode");
    a_led_window: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        SW_CTRL.led_fire |-> !SW_CTRL.pd_connect)
        else $error("led fired while photodiode connected");
    a_precon_float: assert property (@(posedge CLK) disable iff (!rst_n_ff)
        (state_ff == pfs_pkg::PFS_PRECN ##1 state_ff == pfs_pkg::PFS_FLOAT)
        |-> (us_now >= t_a))
        else $error("float entered before precondition time");

endmodule // pfs_sequencer

//--- design/pfs_us_timer.sv
// microsecond tick and elapsed-microsecond counter, restarted per pulse
`timescale 1ns/100ps
`include "pfs_defines.svh"

module pfs_us_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       restart,
    // elapsed time
    output logic [9:0]      us_ff
);

    logic [3:0] div_ff;
    localparam logic [3:0] DIV_LAST = 4'(`PFS_US_CYC - 1);

    // ------------------------------------------------------------
    // divider and counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 4'h0;
            us_ff  <= 10'h000;
        end else if (restart) begin
            // the restart edge already opens the first phase, so it counts as a tick
            div_ff <= 4'h1;
            us_ff  <= 10'h000;
        end else if (div_ff == DIV_LAST) begin
            div_ff <= 4'h0;
            us_ff  <= us_ff + 10'h001;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

endmodule // pfs_us_timer
